// *** design/oag_top.sv ***
`timescale 1ns/1ps
module oag_top (
    input wire logic core_clk, // Processor clock
    input wire logic rst, // Async reset, high
    input wire logic ce, // Clock enable
    input wire logic req, // Decode request strobe
    input wire oag_pkg::oag_mode_t mode, // Operand mode
    input wire logic disp_byte, // Displacement is one byte
    input wire logic [15:0] disp, // Displacement field
    input wire logic [15:0] imm, // Immediate field
    input wire logic imm_byte, // Immediate is one byte
    input wire logic base_sel_fb, // Base: 1 frame, 0 general
    input wire logic idx_sel_dst, // Index: 1 destination, 0 source
    input wire logic [1:0] ri_sel, // Register indirect select
    input wire logic [2:0] reg_num, // General register number
    input wire logic reg_byte, // General register is byte wide
    input wire logic seg_ovr, // Override prefix present
    input wire logic [1:0] seg_ovr_sel, // Override segment
    input wire logic [15:0] general_base_reg, // General base register
    input wire logic [15:0] frame_base_reg, // Frame base register
    input wire logic [15:0] src_index_reg, // Source index register
    input wire logic [15:0] dest_index_reg, // Destination index register
    input wire logic [127:0] gen_regs, // Eight word registers
    input wire logic [63:0] seg_regs, // Four segment registers
    input wire logic [16:0] str_len, // String length in bytes
    input wire logic [7:0] dec_byte, // Byte for decimal check
    output logic mem_vld, // Memory address valid
    output logic [15:0] seg_base, // Segment base
    output logic [15:0] eff_ofs, // Effective offset
    output logic [19:0] phys_addr, // Physical address
    output logic opnd_vld, // Register/immediate operand valid
    output logic [15:0] opnd_val, // Operand value
    output logic opnd_neg, // Operand negative
    output logic str_ok, // String length legal
    output logic pk_dec_ok, // Byte is valid packed decimal
    output logic up_dec_ok // Byte is valid unpacked decimal
);
    // ------------------------------------------------------------
    // Element selection
    // ------------------------------------------------------------
    wire logic [15:0] disp_x;
    wire logic [15:0] base_v;
    wire logic [15:0] idx_v;
    wire logic [15:0] ri_v;
    wire logic use_d;
    wire logic use_b;
    wire logic use_i;
    wire logic is_mem;
    wire logic [15:0] sum;
    wire logic [1:0] seg_imp;
    wire logic [1:0] seg_idx;
    wire logic [15:0] seg_v;
    wire logic [19:0] phys;
    wire logic [15:0] reg_w;
    wire logic [15:0] reg_v;
    wire logic [15:0] imm_x;
    wire logic [15:0] op_v;
    wire logic op_neg;

    // ------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------
    // Picks one sixteen-bit segment word by index
    function automatic logic [15:0] seg_word(input logic [63:0] regs,
        input logic [1:0] idx);
        seg_word = regs[idx*16 +: 16];
    endfunction : seg_word

    assign disp_x = disp_byte ? {{8{disp[7]}}, disp[7:0]} : disp;
    assign base_v = base_sel_fb ? frame_base_reg : general_base_reg;
    assign idx_v = idx_sel_dst ? dest_index_reg : src_index_reg;
    assign ri_v = (ri_sel == oag_pkg::OAG_RI_SRC) ? src_index_reg :
                  (ri_sel == oag_pkg::OAG_RI_DST) ? dest_index_reg :
                  (ri_sel == oag_pkg::OAG_RI_GB) ? general_base_reg :
                  frame_base_reg;

    assign use_d = (mode == oag_pkg::OAG_M_DIRECT) ||
                   (mode == oag_pkg::OAG_M_BASED) ||
                   (mode == oag_pkg::OAG_M_INDEXED) ||
                   (mode == oag_pkg::OAG_M_BI_DISP);
    assign use_b = (mode == oag_pkg::OAG_M_BASED) ||
                   (mode == oag_pkg::OAG_M_BI) ||
                   (mode == oag_pkg::OAG_M_BI_DISP);
    assign use_i = (mode == oag_pkg::OAG_M_INDEXED) ||
                   (mode == oag_pkg::OAG_M_BI) ||
                   (mode == oag_pkg::OAG_M_BI_DISP);
    assign is_mem = (mode != oag_pkg::OAG_M_REG) &&
                    (mode != oag_pkg::OAG_M_IMM);

    // 16-bit sum, carry dropped
    assign sum = (mode == oag_pkg::OAG_M_REG_IND) ? ri_v :
                 16'((use_d ? disp_x : 16'h0000) +
                     (use_b ? base_v : 16'h0000) +
                     (use_i ? idx_v : 16'h0000));

    // ------------------------------------------------------------
    // Segment and physical address
    // ------------------------------------------------------------
    // Frame-based references default to stack segment
    assign seg_imp = ((use_b && base_sel_fb) ||
                      (mode == oag_pkg::OAG_M_REG_IND &&
                       ri_sel == oag_pkg::OAG_RI_FB)) ?
                     oag_pkg::OAG_SEG_SS : oag_pkg::OAG_SEG_DS;
    assign seg_idx = seg_ovr ? seg_ovr_sel : seg_imp;
    assign seg_v = seg_word(seg_regs, seg_idx);
    assign phys = 20'({seg_v, 4'h0} + {4'h0, sum});

    // ------------------------------------------------------------
    // Register and immediate operands
    // ------------------------------------------------------------
    // Byte registers 0-3 low halves, 4-7 high halves of words 0-3
    assign reg_w = gen_regs[reg_num*16 +: 16];
    assign reg_v = !reg_byte ? reg_w :
                   reg_num[2] ? {8'h00, gen_regs[reg_num[1:0]*16 + 8 +: 8]} :
                   {8'h00, reg_w[7:0]};
    assign imm_x = imm_byte ? {8'h00, imm[7:0]} : imm;
    assign op_v = (mode == oag_pkg::OAG_M_IMM) ? imm_x : reg_v;
    assign op_neg = ((mode == oag_pkg::OAG_M_IMM) ? imm_byte : reg_byte) ?
                    op_v[7] : op_v[15];

    // ------------------------------------------------------------
    // Output registers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            mem_vld <= 1'b0;
            seg_base <= oag_pkg::OAG_OFS_RST;
            eff_ofs <= oag_pkg::OAG_OFS_RST;
            phys_addr <= oag_pkg::OAG_PHYS_RST;
            opnd_vld <= 1'b0;
            opnd_val <= oag_pkg::OAG_OFS_RST;
            opnd_neg <= 1'b0;
            str_ok <= 1'b0;
            pk_dec_ok <= 1'b0;
            up_dec_ok <= 1'b0;
        end else if (ce) begin
            mem_vld <= req && is_mem;
            opnd_vld <= req && !is_mem;
            if (req && is_mem) begin
                seg_base <= seg_v;
                eff_ofs <= sum;
                phys_addr <= phys;
            end
            if (req && !is_mem) begin
                opnd_val <= op_v;
                opnd_neg <= op_neg;
            end
            str_ok <= (str_len != 17'h00000) &&
                      (str_len <= oag_pkg::OAG_STR_MAX);
            pk_dec_ok <= (dec_byte[7:4] <= 4'h9) &&
                         (dec_byte[3:0] <= 4'h9);
            up_dec_ok <= (dec_byte <= 8'h09);
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    sequence mem_req_s;
        ce && req && is_mem;
    endsequence

    sequence op_req_s;
        ce && req && !is_mem;
    endsequence

    sequence frozen_s;
        !ce;
    endsequence

    sequence fb_used_s;
        mem_req_s ##0 !seg_ovr ##0 use_b && base_sel_fb;
    endsequence

    direct_ofs_a: assert property (mem_req_s ##0
        mode == oag_pkg::OAG_M_DIRECT |=> eff_ofs == $past(disp_x))
        else $error("direct offset wrong");
    sign_ext_a: assert property (mem_req_s ##0
        mode == oag_pkg::OAG_M_DIRECT && disp_byte |=>
        eff_ofs[15:8] == {8{$past(disp[7])}})
        else $error("byte displacement not sign extended");
    based_ofs_a: assert property (mem_req_s ##0
        mode == oag_pkg::OAG_M_BASED |=>
        eff_ofs == 16'($past(disp_x) + $past(base_v)))
        else $error("based offset wrong");
    indexed_ofs_a: assert property (mem_req_s ##0
        mode == oag_pkg::OAG_M_INDEXED |=>
        eff_ofs == 16'($past(disp_x) + $past(idx_v)))
        else $error("indexed offset wrong");
    bi_ofs_a: assert property (mem_req_s ##0
        mode == oag_pkg::OAG_M_BI |=>
        eff_ofs == 16'($past(base_v) + $past(idx_v)))
        else $error("based indexed offset wrong");
    bid_ofs_a: assert property (mem_req_s ##0
        mode == oag_pkg::OAG_M_BI_DISP |=> eff_ofs ==
        16'($past(base_v) + $past(idx_v) + $past(disp_x)))
        else $error("based indexed disp offset wrong");
    ri_ofs_a: assert property (mem_req_s ##0
        mode == oag_pkg::OAG_M_REG_IND |=> eff_ofs == $past(ri_v))
        else $error("register indirect offset wrong");
    seg_ovr_a: assert property (mem_req_s ##0 seg_ovr |=>
        seg_base == $past(seg_word(seg_regs, seg_ovr_sel)))
        else $error("override segment ignored");
    phys_addr_a: assert property (mem_vld |->
        phys_addr == 20'({seg_base, 4'h0} + {4'h0, eff_ofs}))
        else $error("physical address wrong");
    no_mem_a: assert property (ce && req && !is_mem |=>
        opnd_vld && !mem_vld)
        else $error("register operand made memory cycle");
    imm_val_a: assert property (ce && req &&
        mode == oag_pkg::OAG_M_IMM && !imm_byte |=>
        opnd_val == $past(imm))
        else $error("immediate value wrong");
    neg_word_a: assert property (opnd_vld && opnd_val[15] |->
        opnd_neg)
        else $error("negative word not flagged");
    str_len_a: assert property (ce && $past(ce) &&
        $past(str_len) == 17'h00000 |-> !str_ok)
        else $error("empty string accepted");
    pk_dec_a: assert property (ce && dec_byte[3:0] > 4'h9 |=>
        !pk_dec_ok && !up_dec_ok)
        else $error("bad decimal digit accepted");

    // ------------------------------------------------------------
    // Element, segment and format checks
    // ------------------------------------------------------------
    seg_ss_a: assert property (fb_used_s |=>
        seg_base == $past(seg_regs[47:32]))
        else $error("frame base not in stack segment");
    seg_ds_a: assert property (mem_req_s ##0 !seg_ovr ##0
        mode == oag_pkg::OAG_M_DIRECT |=>
        seg_base == $past(seg_regs[63:48]))
        else $error("direct mode not in data segment");
    base_gb_a: assert property (mem_req_s ##0
        mode == oag_pkg::OAG_M_BASED && !base_sel_fb |=>
        eff_ofs == 16'($past(disp_x) + $past(general_base_reg)))
        else $error("general base not used");
    base_fb_a: assert property (mem_req_s ##0
        mode == oag_pkg::OAG_M_BASED && base_sel_fb |=>
        eff_ofs == 16'($past(disp_x) + $past(frame_base_reg)))
        else $error("frame base not used");
    idx_src_a: assert property (mem_req_s ##0
        mode == oag_pkg::OAG_M_INDEXED && !idx_sel_dst |=>
        eff_ofs == 16'($past(disp_x) + $past(src_index_reg)))
        else $error("source index not used");
    idx_dst_a: assert property (mem_req_s ##0
        mode == oag_pkg::OAG_M_INDEXED && idx_sel_dst |=>
        eff_ofs == 16'($past(disp_x) + $past(dest_index_reg)))
        else $error("destination index not used");
    byte_disp_a: assert property (mem_req_s ##0
        mode == oag_pkg::OAG_M_BASED && disp_byte |=> eff_ofs ==
        16'({{8{$past(disp[7])}}, $past(disp[7:0])} + $past(base_v)))
        else $error("based byte displacement not extended");
    reg_word_a: assert property (op_req_s ##0
        mode == oag_pkg::OAG_M_REG && !reg_byte |=>
        opnd_val == $past(gen_regs[reg_num*16 +: 16]))
        else $error("word register value wrong");
    reg_lo_a: assert property (op_req_s ##0
        mode == oag_pkg::OAG_M_REG && reg_byte && !reg_num[2] |=>
        opnd_val == {8'h00, $past(gen_regs[reg_num*16 +: 8])})
        else $error("low byte register value wrong");
    imm_byte_a: assert property (op_req_s ##0
        mode == oag_pkg::OAG_M_IMM && imm_byte |=>
        opnd_val == {8'h00, $past(imm[7:0])} && opnd_neg == $past(imm[7]))
        else $error("byte immediate wrong");
    freeze_a: assert property (frozen_s |=>
        $stable(eff_ofs) && $stable(opnd_val) && $stable(mem_vld))
        else $error("state moved while clock enable low");
    str_long_a: assert property (ce && str_len > oag_pkg::OAG_STR_MAX
        |=> !str_ok)
        else $error("overlong string accepted");
    str_one_a: assert property (ce && str_len == 17'h00001 |=> str_ok)
        else $error("one byte string refused");
    up_dec_a: assert property (ce && dec_byte[7:4] != 4'h0 |=>
        !up_dec_ok)
        else $error("unpacked digit with high nibble accepted");
    pk_hi_a: assert property (ce && dec_byte[7:4] > 4'h9 |=>
        !pk_dec_ok)
        else $error("bad high decimal digit accepted");
    mem_one_a: assert property (mem_req_s |=> mem_vld && !opnd_vld)
        else $error("memory request not answered");
endmodule : oag_top

// *** design/oag_pkg.sv ***
package oag_pkg;
    localparam int OAG_OFS_W = 16;
    localparam int OAG_SEG_SHIFT = 4;
    localparam int OAG_PHYS_W = 20;
    localparam logic [15:0] OAG_OFS_RST = 16'h0000;
    localparam logic [19:0] OAG_PHYS_RST = 20'h00000;
    localparam logic [16:0] OAG_STR_MAX = 17'h10000;

    // Operand modes
    typedef enum logic [2:0] {
        OAG_M_DIRECT,
        OAG_M_REG_IND,
        OAG_M_BASED,
        OAG_M_INDEXED,
        OAG_M_BI,
        OAG_M_BI_DISP,
        OAG_M_REG,
        OAG_M_IMM
    } oag_mode_t;

    // Register indirect selections
    localparam logic [1:0] OAG_RI_SRC = 2'h0;
    localparam logic [1:0] OAG_RI_DST = 2'h1;
    localparam logic [1:0] OAG_RI_GB = 2'h2;
    localparam logic [1:0] OAG_RI_FB = 2'h3;

    // Segment register indices
    localparam logic [1:0] OAG_SEG_ES = 2'h0;
    localparam logic [1:0] OAG_SEG_CS = 2'h1;
    localparam logic [1:0] OAG_SEG_SS = 2'h2;
    localparam logic [1:0] OAG_SEG_DS = 2'h3;
endpackage : oag_pkg

// *** tb/oag_dec_model.sv ***
`timescale 1ns/1ps
// ----------------------------------------
// Decode-stage register file, fixed values
// ----------------------------------------
module oag_dec_model (
    output logic [15:0] general_base_reg, // General base register
    output logic [15:0] frame_base_reg, // Frame base register
    output logic [15:0] src_index_reg, // Source index register
    output logic [15:0] dest_index_reg, // Destination index register
    output logic [127:0] gen_regs, // Eight word registers
    output logic [63:0] seg_regs // Segment registers
);
    assign general_base_reg = 16'h1234;
    assign frame_base_reg = 16'hff00;
    assign src_index_reg = 16'h8001;
    assign dest_index_reg = 16'h0ff0;
    assign gen_regs = 128'h8f7e_6d5c_4b3a_2918_07f6_e5d4_c3b2_a190;
    assign seg_regs = 64'hf000_3000_2000_1000;
endmodule : oag_dec_model

// *** tb/oag_top_tb_top.sv ***
`timescale 1ns/1ps
module oag_top_tb_top;
    logic core_clk = 0, rst = 1, ce = 1, req = 0;
    oag_pkg::oag_mode_t mode = oag_pkg::OAG_M_DIRECT;
    logic disp_byte = 0, imm_byte = 0, base_sel_fb = 0, idx_sel_dst = 0;
    logic reg_byte = 0, seg_ovr = 0;
    logic [15:0] disp = 16'h0000, imm = 16'h0000;
    logic [1:0] ri_sel = 2'h0, seg_ovr_sel = 2'h0;
    logic [2:0] reg_num = 3'h0;
    logic [16:0] str_len = 17'h00001;
    logic [7:0] dec_byte = 8'h00;
    logic [15:0] gb, fb, si, di, seg_base, eff_ofs, opnd_val;
    logic [127:0] gr;
    logic [63:0] sr;
    logic [19:0] phys_addr;
    logic mem_vld, opnd_vld, opnd_neg, str_ok, pk_dec_ok, up_dec_ok;
    int error_cnt = 0, checks_done = 0, cyc = 0;

    oag_dec_model u_model (.general_base_reg(gb), .frame_base_reg(fb),
        .src_index_reg(si), .dest_index_reg(di), .gen_regs(gr),
        .seg_regs(sr));
    oag_top u_dut (.core_clk(core_clk), .rst(rst), .ce(ce), .req(req),
        .mode(mode), .disp_byte(disp_byte), .disp(disp), .imm(imm),
        .imm_byte(imm_byte), .base_sel_fb(base_sel_fb),
        .idx_sel_dst(idx_sel_dst), .ri_sel(ri_sel), .reg_num(reg_num),
        .reg_byte(reg_byte), .seg_ovr(seg_ovr), .seg_ovr_sel(seg_ovr_sel),
        .general_base_reg(gb), .frame_base_reg(fb), .src_index_reg(si),
        .dest_index_reg(di), .gen_regs(gr), .seg_regs(sr),
        .str_len(str_len), .dec_byte(dec_byte), .mem_vld(mem_vld),
        .seg_base(seg_base), .eff_ofs(eff_ofs), .phys_addr(phys_addr),
        .opnd_vld(opnd_vld), .opnd_val(opnd_val), .opnd_neg(opnd_neg),
        .str_ok(str_ok), .pk_dec_ok(pk_dec_ok), .up_dec_ok(up_dec_ok));

    initial begin
        forever #2 core_clk = ~core_clk;
    end

    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 2000) begin
            error_cnt++;
            conclude();
        end
    end

    task conclude;
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : conclude

    task chk(input string nm, input logic [19:0] got, input logic [19:0] ex);
        checks_done++;
        if (got !== ex) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", nm, ex, got);
        end
    endtask : chk

    task automatic mem(input oag_pkg::oag_mode_t m, input logic db,
        input logic [15:0] d, input logic f, input logic x,
        input logic [1:0] r, input logic ov, input logic [1:0] os);
        logic [15:0] dx, b, i, o;
        logic [1:0] s;
        dx = db ? {{8{d[7]}}, d[7:0]} : d;
        b = f ? fb : gb;
        i = x ? di : si;
        case (m)
            oag_pkg::OAG_M_DIRECT: o = dx;
            oag_pkg::OAG_M_REG_IND: o = r == 0 ? si : r == 1 ? di : r == 2 ? gb : fb;
            oag_pkg::OAG_M_BASED: o = dx + b;
            oag_pkg::OAG_M_INDEXED: o = dx + i;
            oag_pkg::OAG_M_BI: o = b + i;
            default: o = b + i + dx;
        endcase
        if (m == oag_pkg::OAG_M_REG_IND) s = r == 3 ? 2'h2 : 2'h3;
        else s = f && m != oag_pkg::OAG_M_DIRECT && m != oag_pkg::OAG_M_INDEXED ? 2'h2 : 2'h3;
        if (ov) s = os;
        @(negedge core_clk);
        {mode, disp_byte, disp, base_sel_fb, idx_sel_dst} = {m, db, d, f, x};
        {ri_sel, seg_ovr, seg_ovr_sel, req} = {r, ov, os, 1'b1};
        @(negedge core_clk);
        req = 0;
        chk("mem_vld", mem_vld, 1);
        chk("eff_ofs", eff_ofs, o);
        chk("seg_base", seg_base, sr[s*16+:16]);
        chk("phys_addr", phys_addr, {sr[s*16+:16], 4'h0} + {4'h0, o});
    endtask : mem

    task automatic op(input logic im, input logic [2:0] n, input logic b,
        input logic [15:0] iv);
        logic [15:0] w, v;
        w = gr[(b ? {1'b0, n[1:0]} : n)*16+:16];
        v = im ? (b ? {8'h00, iv[7:0]} : iv)
            : (b ? {8'h00, n[2] ? w[15:8] : w[7:0]} : w);
        @(negedge core_clk);
        mode = im ? oag_pkg::OAG_M_IMM : oag_pkg::OAG_M_REG;
        {reg_num, reg_byte, imm_byte, imm, req} = {n, b, b, iv, 1'b1};
        @(negedge core_clk);
        req = 0;
        chk("opnd_vld", opnd_vld, 1);
        chk("mem_vld", mem_vld, 0);
        chk("opnd_val", opnd_val, v);
        chk("opnd_neg", opnd_neg, b ? v[7] : v[15]);
    endtask : op

    task automatic fmt(input logic [16:0] l, input logic [7:0] d);
        @(negedge core_clk);
        {str_len, dec_byte} = {l, d};
        @(negedge core_clk);
        chk("str_ok", str_ok, l != 0 && l <= 17'h10000);
        chk("pk_dec_ok", pk_dec_ok, d[7:4] <= 9 && d[3:0] <= 9);
        chk("up_dec_ok", up_dec_ok, d <= 9);
    endtask : fmt

    task test_mem;
        mem(oag_pkg::OAG_M_DIRECT, 1, 16'h0080, 0, 0, 0, 0, 0);
        mem(oag_pkg::OAG_M_DIRECT, 0, 16'hbeef, 0, 0, 0, 0, 0);
        for (int k = 0; k < 4; k++) mem(oag_pkg::OAG_M_REG_IND, 0, 16'h5555, 0, 0, k[1:0], 0, 0);
        mem(oag_pkg::OAG_M_BASED, 0, 16'hf000, 0, 0, 0, 0, 0);
        mem(oag_pkg::OAG_M_BASED, 1, 16'h00ff, 1, 0, 0, 0, 0);
        mem(oag_pkg::OAG_M_INDEXED, 1, 16'h007f, 0, 0, 0, 0, 0);
        mem(oag_pkg::OAG_M_INDEXED, 0, 16'h1000, 0, 1, 0, 0, 0);
        mem(oag_pkg::OAG_M_BI, 0, 16'h7777, 1, 1, 0, 0, 0);
        mem(oag_pkg::OAG_M_BI_DISP, 0, 16'hf00f, 1, 0, 0, 0, 0);
        for (int k = 0; k < 4; k++) mem(oag_pkg::OAG_M_BI_DISP, 1, 16'h0081, 0, 1, 0, 1, k[1:0]);
        $display("test_mem done");
    endtask : test_mem

    task test_op;
        for (int k = 0; k < 8; k++) begin
            op(0, k[2:0], 0, 16'h0000);
            op(0, k[2:0], 1, 16'h0000);
        end
        op(1, 0, 0, 16'h8001);
        op(1, 0, 1, 16'h7f80);
        $display("test_op done");
    endtask : test_op

    task test_fmt;
        fmt(17'h00000, 8'h99);
        fmt(17'h00001, 8'h9a);
        fmt(17'h10000, 8'ha0);
        fmt(17'h10001, 8'h0a);
        $display("test_fmt done");
    endtask : test_fmt

    task test_ce;
        @(negedge core_clk);
        {ce, mode, disp_byte, disp, seg_ovr, req} = {1'b0, oag_pkg::OAG_M_DIRECT, 1'b0, 16'h4321, 1'b0, 1'b1};
        repeat (3) @(negedge core_clk);
        chk("mem_vld", mem_vld, 0);
        ce = 1;
        @(negedge core_clk);
        req = 0;
        chk("eff_ofs", eff_ofs, 16'h4321);
        $display("test_ce done");
    endtask : test_ce

    initial begin
        repeat (5) @(posedge core_clk);
        @(negedge core_clk);
        rst = 0;
        test_mem();
        test_op();
        test_fmt();
        test_ce();
        conclude();
    end
endmodule : oag_top_tb_top
